// ===== src/pic_consts.vh
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH
// register indices (byte address is four times the index)
`define PIC_IDX_CTRL       2'h0
`define PIC_IDX_STATUS     2'h1
`define PIC_IDX_BASE       2'h2
`define PIC_IDX_HIVEC      2'h3
// control fields
`define PIC_CTRL_VLS_BIT   6
`define PIC_CTRL_CVT_BIT   5
`define PIC_CTRL_RR_BIT    0
// status fields
`define PIC_ST_NMI_BIT     7
`define PIC_ST_HI_BIT      1
`define PIC_ST_NORM_BIT    0
// reset values
`define PIC_CTRL_RST       8'h00
`define PIC_BASE_RST       8'h00
`define PIC_HIVEC_RST      8'h00
// guard key and window length in instructions
`define PIC_KEY_DEF        8'hd8
`define PIC_GUARD_INSNS    4
// response cycle counts
`define PIC_FINISH_CYC     1
`define PIC_PUSH_CYC       2
`define PIC_JMP_CYC        3
`define PIC_RJMP_CYC       2
`define PIC_WAKE_CYC       5
`define PIC_RET_SHORT_CYC  4
`define PIC_RET_LONG_CYC   5
// compact table addresses
`define PIC_CVT_NMI        8'h01
`define PIC_CVT_HI         8'h02
`define PIC_CVT_NORM       8'h03
`endif

// ===== src/pic_cycle_timer.v
`default_nettype none
module pic_cycle_timer #(
  parameter W = 8
) (
  // clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // control
  input  wire         start,
  input  wire [W-1:0] count,
  output wire         busy,
  output wire         done
);
  reg [W-1:0] cnt_q;
  reg         done_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q  <= {W{1'b0}};
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (cnt_q == {{(W-1){1'b0}}, 1'b1}) && !start;
      if (start)
        cnt_q <= count;
      else if (cnt_q != {W{1'b0}})
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign busy = (cnt_q != {W{1'b0}}) || start;
  assign done = done_q;
endmodule
`default_nettype wire

// ===== src/pic_arbiter.v
`default_nettype none
// picks the first pending request at or after start_idx, wrapping
module pic_arbiter #(
  parameter N  = 16,
  parameter IW = 8
) (
  // requests
  input  wire [N-1:0]  req,
  input  wire [IW-1:0] start_idx,
  // grant
  output reg           any,
  output reg  [IW-1:0] idx
);
  integer i;
  integer k;

  always @*
  begin
    any = 1'b0;
    idx = {IW{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      k = (start_idx + i) % N;
      if (req[k])
      begin
        any = 1'b1;
        idx = k[IW-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/pic_controller.v
// Functional notes
// - response is finish one, push two, then three-cycle absolute jump.
// - small program memory uses two-cycle relative jump instead of three.
// - request during multi-cycle instruction waits until that instruction completes.
// - wake from sleep adds five cycles plus the sleep mode start-up time.
// - return takes four or five cycles by program counter width.
// - high level preempts normal handler; normal handler resumes after return.
// - non-maskable served regardless of global enable, never changes it.
// - nothing is accepted while a non-maskable handler runs.
// - several non-maskable pending: lowest vector first, fixed order.
// - high vector register lifts one request to level one over normals.
// - all non-non-maskable vectors default to normal level zero.
// - index zero reset, one non-maskable; those and level one beat normals.
// - fixed scheduling with base zero grants the lowest pending normal vector first.
// - base Y makes Y lowest and Y+1 highest, wrapping.
// - round robin loads base with each acknowledged normal vector.
// - round robin is active when its control bit is one.
// - compact table: non-maskable at 1, level one at 2, normals at 3.
// - status keeps executing levels; each return restores the prior state.
// - location and compact bits written only within four instructions of key.
// - high vector value zero disables level one service.
// - normal executing flag stays set while preempted, cleared on its return.
// - after return one interrupted instruction runs before the next service.
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none
`include "pic_consts.vh"
module pic_controller #(
  parameter N           = 32,
  parameter NMI_MASK    = 32'h0000_0002,
  parameter SMALL_FLASH = 0,
  parameter LONG_PC     = 0,
  parameter KEY         = `PIC_KEY_DEF
) (
  // clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // axi4-lite write address
  input  wire [31:0]   s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // axi4-lite read
  input  wire [31:0]   s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // peripheral requests, bit i is vector i
  input  wire [N-1:0]  irq,
  // core side
  input  wire          global_enable,
  input  wire          insn_retire,
  input  wire          in_sleep,
  input  wire [7:0]    wake_cycles,
  input  wire          guard_key_write,
  input  wire [7:0]    guard_key_data,
  input  wire          handler_return,
  output reg           irq_ack,
  output reg  [7:0]    vector_index,
  output wire          irq_busy,
  output reg           vector_location_select
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RESP = 2'h1;
  localparam ST_RUN  = 2'h2;
  localparam ST_RET  = 2'h3;
  localparam [7:0] RESP_FAST = `PIC_FINISH_CYC + `PIC_PUSH_CYC
                               + (SMALL_FLASH ? `PIC_RJMP_CYC : `PIC_JMP_CYC);
  localparam [7:0] RET_CYC = LONG_PC ? `PIC_RET_LONG_CYC : `PIC_RET_SHORT_CYC;
  localparam [7:0] WAKE_CYC = `PIC_WAKE_CYC;
  localparam [2:0] GUARD_N = `PIC_GUARD_INSNS;
  localparam [7:0] CTRL_RST = `PIC_CTRL_RST;
  reg [1:0]  state_q;
  reg        compact_q;
  reg        rr_q;
  reg [7:0]  base_q;
  reg [7:0]  hivec_q;
  reg        nmi_ex_q;
  reg        hi_ex_q;
  reg        norm_ex_q;
  reg [2:0]  guard_q;
  reg        one_insn_q;
  reg [2:0]  pend_lvl_q;
  reg [7:0]  pend_raw_q;
  reg [2:0]  ret_lvl_q;
  // axi
  reg        aw_got_q;
  reg        w_got_q;
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  wire [N-1:0] nmi_req = irq & NMI_MASK[N-1:0];
  wire [7:0]   hv = hivec_q;
  wire         hi_valid = (hv != 8'h00) && (hv < N) && !NMI_MASK[hv % N];
  wire [N-1:0] hi_bit = hi_valid ? ({{(N-1){1'b0}}, 1'b1} << hv) : {N{1'b0}};
  // every other vector is normal
  // normals exclude reset, non-maskable and the level one vector
  wire [N-1:0] norm_req = irq & ~NMI_MASK[N-1:0] & ~hi_bit & ~{{(N-1){1'b0}}, 1'b1};
  wire         hi_req = |(irq & hi_bit);
  wire         nmi_any;
  wire [7:0]   nmi_idx;
  wire         norm_any;
  wire [7:0]   norm_idx;
  // search starts one past the base, wrapping
  wire [31:0]  norm_start_w = ({24'h000000, base_q} + 32'h0000_0001) % N;
  wire [7:0]   norm_start = norm_start_w[7:0];
  pic_arbiter #(.N(N), .IW(8)) u_nmi_arb (
    .req       (nmi_req),
    .start_idx (8'h00),
    .any       (nmi_any),
    .idx       (nmi_idx)
  );
  pic_arbiter #(.N(N), .IW(8)) u_norm_arb (
    .req       (norm_req),
    .start_idx (norm_start),
    .any       (norm_any),
    .idx       (norm_idx)
  );
  wire tmr_busy;
  wire tmr_done;
  reg  tmr_start;
  reg  [7:0] tmr_count;
  pic_cycle_timer #(.W(8)) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (tmr_start),
    .count   (tmr_count),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );
  // selection of the next request to accept
  // level one above normals, zero disables
  wire       can_hi   = global_enable && hi_req && !hi_ex_q;
  // normals only when no handler runs
  wire       can_norm = global_enable && norm_any && !hi_ex_q && !norm_ex_q;
  // nothing over a running non-maskable handler
  wire       take     = !nmi_ex_q && (nmi_any || can_hi || can_norm);
  wire [2:0] take_lvl = nmi_any ? 3'b100 : (can_hi ? 3'b010 : 3'b001);
  wire [7:0] take_vec = nmi_any ? nmi_idx : (can_hi ? hv : norm_idx);
  wire [7:0] out_vec = !compact_q ? pend_raw_q
                     : (pend_lvl_q[2] ? `PIC_CVT_NMI
                     : (pend_lvl_q[1] ? `PIC_CVT_HI : `PIC_CVT_NORM));

  // state machine
  always @*
  begin
    tmr_start = 1'b0;
    tmr_count = 8'h00;
    // return count, return beats a new take
    if ((state_q == ST_RUN) && handler_return)
    begin
      tmr_start = 1'b1;
      tmr_count = RET_CYC;
    end
    else if (state_q != ST_RESP && state_q != ST_RET && take && insn_retire && !one_insn_q)
    begin
      tmr_start = 1'b1;
      tmr_count = in_sleep ? RESP_FAST + WAKE_CYC + wake_cycles : RESP_FAST;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q      <= ST_IDLE;
      nmi_ex_q     <= 1'b0;
      hi_ex_q      <= 1'b0;
      norm_ex_q    <= 1'b0;
      one_insn_q   <= 1'b0;
      pend_lvl_q   <= 3'b000;
      pend_raw_q   <= 8'h00;
      ret_lvl_q    <= 3'b000;
      irq_ack      <= 1'b0;
      vector_index <= 8'h00;
    end
    else
    begin
      irq_ack <= 1'b0;
      if (one_insn_q && insn_retire)
        one_insn_q <= 1'b0;
      case (state_q)
        ST_IDLE, ST_RUN:
        begin
          // accept only at an instruction boundary
          if (tmr_start && (state_q == ST_RUN) && handler_return)
          begin
            state_q   <= ST_RET;
            ret_lvl_q <= nmi_ex_q ? 3'b100 : (hi_ex_q ? 3'b010 : 3'b001);
          end
          else if (tmr_start)
          begin
            state_q    <= ST_RESP;
            pend_lvl_q <= take_lvl;
            pend_raw_q <= take_vec;
          end
        end
        ST_RESP:
        begin
          if (tmr_done)
          begin
            // vector and level in one cycle
            irq_ack      <= 1'b1;
            vector_index <= out_vec;
            if (pend_lvl_q[2])
              nmi_ex_q <= 1'b1;
            if (pend_lvl_q[1])
              hi_ex_q <= 1'b1;
            if (pend_lvl_q[0])
              norm_ex_q <= 1'b1;
            state_q <= ST_RUN;
          end
        end
        ST_RET:
        begin
          if (tmr_done)
          begin
            if (ret_lvl_q[2])
              nmi_ex_q <= 1'b0;
            else if (ret_lvl_q[1])
              hi_ex_q <= 1'b0;
            else
              norm_ex_q <= 1'b0;
            one_insn_q <= 1'b1;
            state_q <= (ret_lvl_q[2] ? (hi_ex_q | norm_ex_q)
                       : ret_lvl_q[1] ? norm_ex_q : 1'b0) ? ST_RUN : ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  assign irq_busy = tmr_busy || (state_q == ST_RESP) || (state_q == ST_RET);
  // axi4-lite write path
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  wire   wr_go   = aw_got_q && w_got_q && !s_axi_bvalid;
  wire   wr_map  = (awaddr_q[31:4] == 28'h0) && (awaddr_q[1:0] == 2'b00);
  wire   [1:0] wr_idx = awaddr_q[3:2];
  wire   wr_b0   = wr_go && wr_map && wstrb_q[0];
  wire   ack_norm = irq_ack && pend_lvl_q[0];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      compact_q <= CTRL_RST[`PIC_CTRL_CVT_BIT];
      vector_location_select <= 1'b0;
      rr_q     <= 1'b0;
      base_q   <= `PIC_BASE_RST;
      hivec_q  <= `PIC_HIVEC_RST;
      guard_q  <= 3'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (guard_key_write && guard_key_data == KEY)
        guard_q <= GUARD_N;
      else if (insn_retire && guard_q != 3'h0)
        guard_q <= guard_q - 3'h1;
      if (wr_go)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_b0 && wr_idx == `PIC_IDX_CTRL)
      begin
        rr_q <= wdata_q[`PIC_CTRL_RR_BIT];
        if (guard_q != 3'h0)
        begin
          compact_q              <= wdata_q[`PIC_CTRL_CVT_BIT];
          vector_location_select <= wdata_q[`PIC_CTRL_VLS_BIT];
        end
      end
      if (wr_b0 && wr_idx == `PIC_IDX_HIVEC)
        hivec_q <= wdata_q[7:0];
      if (rr_q && ack_norm)
        base_q <= pend_raw_q;
      else if (wr_b0 && wr_idx == `PIC_IDX_BASE)
        base_q <= wdata_q[7:0];
    end
  end
  // axi4-lite read path
  assign s_axi_arready = !s_axi_rvalid;
  wire [1:0] rd_idx = s_axi_araddr[3:2];
  wire       rd_map = (s_axi_araddr[31:4] == 28'h0) && (s_axi_araddr[1:0] == 2'b00);
  reg  [7:0] rd_byte;
  always @*
  begin
    rd_byte = 8'h00;
    if (rd_idx == `PIC_IDX_CTRL)
      rd_byte = {1'b0, vector_location_select, compact_q, 4'h0, rr_q};
    else if (rd_idx == `PIC_IDX_STATUS)
      rd_byte = {nmi_ex_q, 5'h00, hi_ex_q, norm_ex_q};
    else if (rd_idx == `PIC_IDX_BASE)
      rd_byte = base_q;
    else
      rd_byte = hivec_q;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_map ? {24'h000000, rd_byte} : 32'h0000_0000;
      s_axi_rresp  <= rd_map ? 2'b00 : 2'b10;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== testbench/pic_core_model.sv
`default_nettype none
// processor core stand-in: paces instruction boundaries and executes returns
module pic_core_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // bench control
  input  wire logic slow,
  input  wire logic ret_req,
  // from controller
  input  wire logic irq_busy,
  // to controller
  output var  logic insn_retire,
  output var  logic handler_return
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] ph_q;
  logic       pend_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ph_q           <= 2'h0;
      pend_q         <= 1'b0;
      insn_retire    <= 1'b0;
      handler_return <= 1'b0;
    end
    else
    begin
      ph_q           <= ph_q + 2'h1;
      // slow mode stands for four-cycle instructions
      insn_retire    <= !slow || ph_q == 2'h3;
      // return only once the controller is quiet, one pulse each
      handler_return <= pend_q && !irq_busy && !handler_return;
      pend_q         <= ret_req || (pend_q && (irq_busy || handler_return));
    end
  end
endmodule
`default_nettype wire

// ===== testbench/pic_controller_assertions.sv
`default_nettype none
module pic_controller_assertions (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // register read channel
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic [31:0] s_axi_rdata,
  // core side
  input  wire logic        insn_retire,
  input  wire logic        in_sleep,
  input  wire logic        handler_return,
  input  wire logic        irq_ack,
  input  wire logic [7:0]  vector_index,
  input  wire logic        irq_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_take;
    $rose(irq_busy) && insn_retire && !in_sleep && !handler_return;
  endsequence
  sequence s_resp;
    irq_busy [*7];
  endsequence
  sequence s_ret;
    handler_return && $rose(irq_busy);
  endsequence

  AST_RESP_SEQ: assert property (s_take ##1 s_resp |=> irq_ack)
    else $error("ack missing after response sequence");
  AST_ACK_LAT: assert property (irq_ack && !$past(in_sleep, 8) |->
    $past(insn_retire, 8) && !$past(irq_busy, 9))
    else $error("ack not eight cycles after an instruction boundary");
  AST_RET: assert property (s_ret |=> irq_busy [*4])
    else $error("return sequence shorter than four cycles");
  AST_ACK_PULSE: assert property (irq_ack |=> !irq_ack)
    else $error("ack longer than one cycle");
  AST_VEC_HOLD: assert property (!irq_ack |-> $stable(vector_index))
    else $error("vector changed without ack");
  AST_NO_VEC0: assert property (irq_ack |-> vector_index != 8'h00)
    else $error("reset vector acknowledged");
  AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule

bind pic_controller pic_controller_assertions u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata), .insn_retire(insn_retire), .in_sleep(in_sleep),
  .handler_return(handler_return), .irq_ack(irq_ack), .vector_index(vector_index),
  .irq_busy(irq_busy)
);
`default_nettype wire

// ===== testbench/test_priority_interrupt_controller.sv
`default_nettype none
module test_priority_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ps;

  // arbitrary unlock key
  localparam logic [7:0] KEY_V = 8'h5a;
  // accept edge, response count, done and ack flops
  localparam int RESP_LAT = 1 + (1 + 2 + 3) + 2;
  logic [31:0] awaddr, wdata, araddr, rdata, irq, m;
  logic [1:0]  bresp, rresp;
  logic [7:0]  wake, kd, vec, b, e;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, ge, slp, kw, slow, ret_req, ret, ack, busy, vls;
  logic        retire;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          seed, lat;

  pic_controller #(.NMI_MASK(32'h0000_0006), .KEY(KEY_V)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .global_enable(ge), .insn_retire(retire), .in_sleep(slp), .wake_cycles(wake),
    .guard_key_write(kw), .guard_key_data(kd), .handler_return(ret), .irq_ack(ack),
    .vector_index(vec), .irq_busy(busy), .vector_location_select(vls)
  );

  pic_core_model u_core (
    .aclk(aclk), .aresetn(aresetn), .slow(slow), .ret_req(ret_req), .irq_busy(busy),
    .insn_retire(retire), .handler_return(ret)
  );

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic end_of_test;
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        @(posedge aclk iff awready);
        awvalid <= 1'b0;
      end
      begin
        @(posedge aclk iff wready);
        wvalid <= 1'b0;
      end
    join
    @(posedge aclk iff bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk iff arready);
    arvalid <= 1'b0;
    @(posedge aclk iff rvalid);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask

  // counts edges from the request until ack is seen, at most lim
  task automatic get_ack(input int lim);
    lat = 0;
    do
    begin
      @(posedge aclk);
      lat++;
    end
    while (ack !== 1'b1 && lat < lim);
  endtask

  task automatic serve(input logic [31:0] mk, input logic [7:0] ev, input int el);
    irq <= irq | mk;
    get_ack(200);
    irq <= 32'h0;
    chk(32'(vec), 32'(ev));
    if (el > 0)
      chk(32'(lat), 32'(el));
  endtask

  task automatic ret_h;
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
    repeat (12) @(posedge aclk);
  endtask

  // first pending normal vector after the base, wrapping
  function automatic logic [7:0] exp_norm(input logic [31:0] mk, input logic [7:0] bs);
    logic [7:0] k;
    exp_norm = 8'h00;
    for (int j = 32; j >= 1; j--)
    begin
      k = 8'((int'(bs) + j) % 32);
      if (mk[k[4:0]])
        exp_norm = k;
    end
  endfunction

  initial
  begin
    seed = 32'h1a5318bb;
    {awaddr, wdata, araddr, irq, wake, kd} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ge, slp, kw, slow, ret_req} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 5; a++)
      rd(32'(a * 4), 32'h0, a == 4 ? 2'h2 : 2'h0);
    wr(32'h10, 32'h1, 2'h2);
    ge <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      m = $random(seed) & 32'hffff_fff8;
      if (m == 32'h0)
        m = 32'h100;
      if (i < 7)
        b = 8'($random(seed) & 31);
      wr(32'h0, 32'(i >= 6), 2'h0);
      if (i < 7)
        wr(32'h8, 32'(b), 2'h0);
      e = exp_norm(m, b);
      serve(m, e, RESP_LAT);
      if (i >= 6)
        rd(32'h8, 32'(e), 2'h0);
      b = e;
      ret_h();
    end
    ge <= 1'b0;
    serve(32'h6, 8'h1, RESP_LAT);
    rd(32'h4, 32'h80, 2'h0);
    ge <= 1'b1;
    irq <= 32'h10;
    get_ack(20);
    chk(32'(lat), 32'd20);
    ret_h();
    serve(32'h10, 8'h4, 0);
    rd(32'h4, 32'h01, 2'h0);
    wr(32'hc, 32'h7, 2'h0);
    serve(32'h80, 8'h7, RESP_LAT);
    rd(32'h4, 32'h03, 2'h0);
    ret_h();
    rd(32'h4, 32'h01, 2'h0);
    ret_h();
    rd(32'h4, 32'h00, 2'h0);
    slp <= 1'b1;
    wake <= 8'h3;
    serve(32'h10, 8'h4, RESP_LAT + 5 + 3);
    slp <= 1'b0;
    ret_h();
    slow <= 1'b1;
    wr(32'h0, 32'h61, 2'h0);
    rd(32'h0, 32'h01, 2'h0);
    kw <= 1'b1;
    kd <= KEY_V;
    @(posedge aclk);
    kw <= 1'b0;
    wr(32'h0, 32'h60, 2'h0);
    rd(32'h0, 32'h60, 2'h0);
    chk(32'(vls), 32'h1);
    serve(32'h20, 8'h3, 0);
    ret_h();
    slow <= 1'b0;
    wr(32'h0, 32'h0, 2'h0);
    rd(32'h0, 32'h60, 2'h0);
    serve(32'h2, 8'h1, 0);
    ret_h();
    serve(32'h80, 8'h2, 0);
    ret_h();
    end_of_test();
  end
endmodule
`default_nettype wire
